/* File: afpp_defs.svh */
// register offsets, reset values, masks and limits of the config bank
// assumes inclusion by bare name from the package and the bench
`ifndef AFPP_DEFS_SVH
`define AFPP_DEFS_SVH

// register indices; the byte address is four times the index
`define AFPP_IDX_AFE3      10'h106
`define AFPP_IDX_AFE4      10'h107
`define AFPP_IDX_VINT      10'h108
`define AFPP_IDX_VDIV      10'h109
`define AFPP_IDX_AINT      10'h10A
`define AFPP_IDX_ADIV      10'h10B
`define AFPP_IDX_VFR0      10'h10C
`define AFPP_IDX_VFR1      10'h10D
`define AFPP_IDX_VFR2      10'h10E
`define AFPP_IDX_VFR3      10'h10F
`define AFPP_IDX_AFR0      10'h110
`define AFPP_IDX_AFR1      10'h111
`define AFPP_IDX_AFR2      10'h112
`define AFPP_IDX_AFR3      10'h113
`define AFPP_IDX_PIN1      10'h114
`define AFPP_IDX_PIN2      10'h115
`define AFPP_IDX_PIN3      10'h116
`define AFPP_NREG          17

// reset values
`define AFPP_RST_AFE3      8'h04
`define AFPP_RST_AFE4      8'h07
`define AFPP_RST_VINT      8'h0F
`define AFPP_RST_VDIV      8'h04
`define AFPP_RST_AINT      8'h0A
`define AFPP_RST_ADIV      8'h10
`define AFPP_RST_VFR0      8'hFE
`define AFPP_RST_VFR1      8'hE2
`define AFPP_RST_VFR2      8'h2B
`define AFPP_RST_AFR0      8'h09
`define AFPP_RST_AFR1      8'hD7
`define AFPP_RST_AFR2      8'h98
`define AFPP_RST_ZERO      8'h00

// writable bits; the rest read as zero
`define AFPP_MASK_FULL     8'hFF
`define AFPP_MASK_AFE4     8'h0F
`define AFPP_MASK_COEF     8'h3F
`define AFPP_MASK_TOP      8'h01
`define AFPP_MASK_PIN3     8'h1F

// legal coefficient ranges and bus answers
`define AFPP_INT_MIN       6'h08
`define AFPP_INT_MAX       6'h3B
`define AFPP_DIV_MIN       6'h02
`define AFPP_DIV_MAX       6'h3F
`define AFPP_RESP_OKAY     2'h0
`define AFPP_RESP_SLVERR   2'h2
`endif

/* File: afpp_pkg.sv */
// field layouts and bus-side state of the config bank
// assumes afpp_defs.svh is on the include path
package afpp_pkg;
  `include "afpp_defs.svh"

  // front-end filter, boost and clamp controls
  typedef struct packed {
    logic [2:0] filter_skip;
    logic [2:0] resistance_boost;
    logic [1:0] clamp_power;
  } afpp_afe3_t;

  // reference source; upper nibble reads zero
  typedef struct packed {
    logic [3:0] rsv;
    logic       ref_current_source;
    logic [2:0] trim;
  } afpp_afe4_t;

  // synthesiser coefficient byte
  typedef struct packed {
    logic [1:0] rsv;
    logic [5:0] coef;
  } afpp_coef_t;

  // control pad enables, msb first
  typedef struct packed {
    logic field;
    logic data_valid;
    logic ir_send;
    logic ir_receive;
    logic interrupt;
    logic select_clock;
    logic general1;
    logic general0;
  } afpp_pin1_t;

  // video and serial audio pad enables
  typedef struct packed {
    logic [3:0] audio;
    logic       pixel_clock;
    logic       video_bus;
    logic       vertical;
    logic       horizontal;
  } afpp_pin2_t;

  // codec link, pll clock and audio clock outputs
  typedef struct packed {
    logic [2:0] rsv;
    logic       link_in;
    logic       link_out;
    logic       pll_clock;
    logic       word_clock_out;
    logic       bit_clock_out;
  } afpp_pin3_t;

  // register slave state
  typedef struct packed {
    logic        aw_held;
    logic [11:0] awaddr;
    logic        w_held;
    logic [7:0]  wbyte;
    logic        wlane;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [30:0] vmul;
    logic [30:0] amul;
  } afpp_bus_t;
endpackage

/* File: afpp_rst_sync.sv */
// reset release synchroniser
// assumes rst_n may drop at any time and rise asynchronously to mclk
`timescale 1ns/1ps
module afpp_rst_sync
  import afpp_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  output logic      rst_sync_n
);
  typedef struct packed {
    logic [1:0] shift;
  } afpp_rsync_t;

  afpp_rsync_t s;
  afpp_rsync_t next_s;

  // shift ones in; only the second stage is read
  always_comb begin
    next_s       = s;
    next_s.shift = {s.shift[0], 1'b1};
  end

  // assert at once, release two edges later
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rst_sync_n = s.shift[1];
endmodule

/* File: afpp_cfg_reg.sv */
// one byte of configuration storage with a writable-bit mask
// assumes the write strobe and data come from the same clock domain
`timescale 1ns/1ps
module afpp_cfg_reg
  import afpp_pkg::*;
#(
  parameter logic [7:0] RST  = 8'h00,
  parameter logic [7:0] MASK = 8'hFF
)(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q
);
  typedef struct packed {
    logic [7:0] value;
  } afpp_byte_t;

  afpp_byte_t s;
  afpp_byte_t next_s;

  // masked bits stay zero whatever software writes
  always_comb begin
    next_s = s;
    if (wr) begin
      next_s.value = wdata & MASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s.value <= RST & MASK;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.value;
endmodule

/* File: afpp_regs_top.sv */
// front-end, synthesiser and pad-enable configuration bank
// assumes an axi4-lite master on mclk; outputs feed analog and pad cells
`timescale 1ns/1ps

// Operation
// - set bit bypasses channel anti-alias filter
// - boost bits per channel, channel 1 resets on
// - clamp power for channels 3,2, reset off
// - reference current source, 1 on-chip resistor
// - integer coefficient 8..59, resets 0x0F/0x0A
// - post divide 2..63, resets 0x04/0x10
// - first fraction byte holds bits 7:0
// - second fraction byte holds bits 15:8
// - third fraction byte holds bits 23:16
// - fourth holds bit 24, rest zero
// - field and data-valid pad enables
// - infrared send and receive pad enables
// - interrupt and select/clock pad enables
// - general pads 1 and 0 enables
// - four serial audio pad enables
// - pixel clock and video bus enables
// - vertical and horizontal sync enables
// - codec link input and output pad enables
// - pll clock pad enable
// - audio clock out enables, reserved zero
module afpp_regs_top
  import afpp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             filter_skip_chan3,
  output logic             filter_skip_chan2,
  output logic             filter_skip_chan1,
  output logic             resistance_boost_chan3,
  output logic             resistance_boost_chan2,
  output logic             resistance_boost_chan1,
  output logic             clamp_power_chan3,
  output logic             clamp_power_chan2,
  output logic             ref_current_source,
  output logic      [2:0]  ref_trim,
  output logic      [5:0]  video_synth_integer,
  output logic      [5:0]  video_synth_postdiv,
  output logic      [5:0]  second_synth_integer,
  output logic      [5:0]  second_synth_postdiv,
  output logic      [24:0] video_synth_fraction,
  output logic      [24:0] second_synth_fraction,
  output logic      [30:0] video_synth_multiplier,
  output logic      [30:0] second_synth_multiplier,
  output logic             field_pad_drive,
  output logic             data_valid_pad_drive,
  output logic             infrared_send_pad_drive,
  output logic             infrared_receive_pad_drive,
  output logic             interrupt_pad_drive,
  output logic             select_or_port_clock_pad_drive,
  output logic             general_pad1_drive,
  output logic             general_pad0_drive,
  output logic             audio_serial_out_pad_drive,
  output logic             audio_word_clock_in_pad_drive,
  output logic             audio_bit_clock_in_pad_drive,
  output logic             audio_serial_in_pad_drive,
  output logic             pixel_clock_pad_drive,
  output logic             video_bus_pad_drive,
  output logic             vertical_sync_pad_drive,
  output logic             horizontal_sync_pad_drive,
  output logic             codec_link_input_pads_drive,
  output logic             codec_link_output_pads_drive,
  output logic             pll_clock_pad_drive,
  output logic             audio_word_clock_out_pad_drive,
  output logic             audio_bit_clock_out_pad_drive
);
  localparam int NREG = `AFPP_NREG;

  // table order follows the index order
  localparam logic [7:0] RST_TBL [NREG] = '{
    `AFPP_RST_AFE3, `AFPP_RST_AFE4, `AFPP_RST_VINT, `AFPP_RST_VDIV,
    `AFPP_RST_AINT, `AFPP_RST_ADIV, `AFPP_RST_VFR0, `AFPP_RST_VFR1,
    `AFPP_RST_VFR2, `AFPP_RST_ZERO, `AFPP_RST_AFR0, `AFPP_RST_AFR1,
    `AFPP_RST_AFR2, `AFPP_RST_ZERO, `AFPP_RST_ZERO, `AFPP_RST_ZERO,
    `AFPP_RST_ZERO};
  localparam logic [7:0] MASK_TBL [NREG] = '{
    `AFPP_MASK_FULL, `AFPP_MASK_AFE4, `AFPP_MASK_COEF, `AFPP_MASK_COEF,
    `AFPP_MASK_COEF, `AFPP_MASK_COEF, `AFPP_MASK_FULL, `AFPP_MASK_FULL,
    `AFPP_MASK_FULL, `AFPP_MASK_TOP, `AFPP_MASK_FULL, `AFPP_MASK_FULL,
    `AFPP_MASK_FULL, `AFPP_MASK_TOP, `AFPP_MASK_FULL, `AFPP_MASK_FULL,
    `AFPP_MASK_PIN3};

  // slot numbers relative to the first index
  localparam logic [9:0] BASE = `AFPP_IDX_AFE3;
  localparam logic [4:0] S_AFE3 = 5'(`AFPP_IDX_AFE3 - `AFPP_IDX_AFE3);
  localparam logic [4:0] S_AFE4 = 5'(`AFPP_IDX_AFE4 - `AFPP_IDX_AFE3);
  localparam logic [4:0] S_VINT = 5'(`AFPP_IDX_VINT - `AFPP_IDX_AFE3);
  localparam logic [4:0] S_VDIV = 5'(`AFPP_IDX_VDIV - `AFPP_IDX_AFE3);
  localparam logic [4:0] S_AINT = 5'(`AFPP_IDX_AINT - `AFPP_IDX_AFE3);
  localparam logic [4:0] S_ADIV = 5'(`AFPP_IDX_ADIV - `AFPP_IDX_AFE3);
  localparam logic [4:0] S_VFR0 = 5'(`AFPP_IDX_VFR0 - `AFPP_IDX_AFE3);
  localparam logic [4:0] S_VFR1 = 5'(`AFPP_IDX_VFR1 - `AFPP_IDX_AFE3);
  localparam logic [4:0] S_VFR2 = 5'(`AFPP_IDX_VFR2 - `AFPP_IDX_AFE3);
  localparam logic [4:0] S_VFR3 = 5'(`AFPP_IDX_VFR3 - `AFPP_IDX_AFE3);
  localparam logic [4:0] S_AFR0 = 5'(`AFPP_IDX_AFR0 - `AFPP_IDX_AFE3);
  localparam logic [4:0] S_AFR1 = 5'(`AFPP_IDX_AFR1 - `AFPP_IDX_AFE3);
  localparam logic [4:0] S_AFR2 = 5'(`AFPP_IDX_AFR2 - `AFPP_IDX_AFE3);
  localparam logic [4:0] S_AFR3 = 5'(`AFPP_IDX_AFR3 - `AFPP_IDX_AFE3);
  localparam logic [4:0] S_PIN1 = 5'(`AFPP_IDX_PIN1 - `AFPP_IDX_AFE3);
  localparam logic [4:0] S_PIN2 = 5'(`AFPP_IDX_PIN2 - `AFPP_IDX_AFE3);
  localparam logic [4:0] S_PIN3 = 5'(`AFPP_IDX_PIN3 - `AFPP_IDX_AFE3);

  logic             rst_sync_n;
  afpp_bus_t        s;
  afpp_bus_t        next_s;
  logic [7:0]       cfg_q [NREG];
  logic [NREG-1:0]  wr_en;
  logic             do_wr;
  logic             wr_hit;
  logic             rd_hit;
  logic [4:0]       wr_slot;
  logic [4:0]       rd_slot;
  logic             wr_legal;
  afpp_afe3_t       afe3;
  afpp_afe4_t       afe4;
  afpp_coef_t       vint;
  afpp_coef_t       vdiv;
  afpp_coef_t       aint;
  afpp_coef_t       adiv;
  afpp_pin1_t       pin1;
  afpp_pin2_t       pin2;
  afpp_pin3_t       pin3;
  afpp_coef_t       wcoef;

  afpp_rst_sync u_rst (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .rst_sync_n (rst_sync_n)
  );

  // decode a byte address into a slot of the bank
  function automatic logic [10:0] afpp_decode(input logic [11:0] a);
    logic [9:0] idx;
    logic [9:0] off;
    idx = a[11:2];
    off = idx - BASE;
    afpp_decode = {(idx >= BASE) && (off < 10'(NREG)), off};
  endfunction

  // reserved bits are masked off, so careless writes read back zero
  generate
    for (genvar i = 0; i < NREG; i++) begin : g_reg
      afpp_cfg_reg #(
        .RST  (RST_TBL[i]),
        .MASK (MASK_TBL[i])
      ) u_reg (
        .mclk  (mclk),
        .rst_n (rst_sync_n),
        .wr    (wr_en[i]),
        .wdata (s.wbyte),
        .q     (cfg_q[i])
      );
    end
  endgenerate

  // write commits once both halves are held and no answer is pending
  always_comb begin
    logic [10:0] wd;
    logic [10:0] rd;
    wd       = afpp_decode(s.awaddr);
    rd       = afpp_decode(araddr);
    wr_hit   = wd[10];
    wr_slot  = wd[4:0];
    rd_hit   = rd[10];
    rd_slot  = rd[4:0];
    do_wr    = s.aw_held && s.w_held && !s.bvalid;
    wcoef    = afpp_coef_t'(s.wbyte);
    wr_legal = 1'b1;
    // out-of-range coefficients are dropped so the loop never sees them
    if (wr_slot == S_VINT || wr_slot == S_AINT) begin
      wr_legal = wcoef.coef >= `AFPP_INT_MIN &&
                 wcoef.coef <= `AFPP_INT_MAX;
    end
    if (wr_slot == S_VDIV || wr_slot == S_ADIV) begin
      wr_legal = wcoef.coef >= `AFPP_DIV_MIN &&
                 wcoef.coef <= `AFPP_DIV_MAX;
    end
    for (int i = 0; i < NREG; i++) begin
      wr_en[i] = do_wr && wr_hit && s.wlane && wr_legal &&
                 wr_slot == 5'(i);
    end
  end

  // field views of the stored bytes
  assign afe3 = afpp_afe3_t'(cfg_q[S_AFE3]);
  assign afe4 = afpp_afe4_t'(cfg_q[S_AFE4]);
  assign vint = afpp_coef_t'(cfg_q[S_VINT]);
  assign vdiv = afpp_coef_t'(cfg_q[S_VDIV]);
  assign aint = afpp_coef_t'(cfg_q[S_AINT]);
  assign adiv = afpp_coef_t'(cfg_q[S_ADIV]);
  assign pin1 = afpp_pin1_t'(cfg_q[S_PIN1]);
  assign pin2 = afpp_pin2_t'(cfg_q[S_PIN2]);
  assign pin3 = afpp_pin3_t'(cfg_q[S_PIN3]);

  // bus channel handling
  always_comb begin
    next_s = s;
    if (awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr  = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wbyte  = wdata[7:0];
      next_s.wlane  = wstrb[0];
    end
    if (do_wr) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = wr_hit ? `AFPP_RESP_OKAY : `AFPP_RESP_SLVERR;
    end else if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    // each half is refused while held or while the answer waits
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready  = !next_s.w_held && !next_s.bvalid;
    if (arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = rd_hit ? `AFPP_RESP_OKAY : `AFPP_RESP_SLVERR;
      next_s.rdata  = rd_hit ? {24'h000000, cfg_q[rd_slot]} : 32'h00000000;
    end else if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    next_s.arready = !next_s.rvalid;
    // fixed point 6.25: integer above, fraction below
    next_s.vmul = {vint.coef, video_synth_fraction};
    next_s.amul = {aint.coef, second_synth_fraction};
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // bus answers
  assign awready = s.awready;
  assign wready  = s.wready;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = s.arready;
  assign rvalid  = s.rvalid;
  assign rresp   = s.rresp;
  assign rdata   = s.rdata;

  // front-end controls
  assign filter_skip_chan3      = afe3.filter_skip[2];
  assign filter_skip_chan2      = afe3.filter_skip[1];
  assign filter_skip_chan1      = afe3.filter_skip[0];
  assign resistance_boost_chan3 = afe3.resistance_boost[2];
  assign resistance_boost_chan2 = afe3.resistance_boost[1];
  assign resistance_boost_chan1 = afe3.resistance_boost[0];
  assign clamp_power_chan3      = afe3.clamp_power[1];
  assign clamp_power_chan2      = afe3.clamp_power[0];
  assign ref_current_source     = afe4.ref_current_source;
  assign ref_trim               = afe4.trim; // upper nibble masked

  // synthesiser coefficients
  assign video_synth_integer  = vint.coef;
  assign second_synth_integer = aint.coef;
  assign video_synth_postdiv  = vdiv.coef;
  assign second_synth_postdiv = adiv.coef;
  // top byte carries one bit; the others are masked to zero
  assign video_synth_fraction = {cfg_q[S_VFR3][0],
                                 cfg_q[S_VFR2],
                                 cfg_q[S_VFR1],
                                 cfg_q[S_VFR0]};
  assign second_synth_fraction = {cfg_q[S_AFR3][0],
                                  cfg_q[S_AFR2],
                                  cfg_q[S_AFR1],
                                  cfg_q[S_AFR0]};
  assign video_synth_multiplier  = s.vmul;
  assign second_synth_multiplier = s.amul;

  // pad cells tri-state whenever an enable reads zero
  assign field_pad_drive                = pin1.field;
  assign data_valid_pad_drive           = pin1.data_valid;
  assign infrared_send_pad_drive        = pin1.ir_send;
  assign infrared_receive_pad_drive     = pin1.ir_receive;
  assign interrupt_pad_drive            = pin1.interrupt;
  assign select_or_port_clock_pad_drive = pin1.select_clock;
  assign general_pad1_drive             = pin1.general1;
  assign general_pad0_drive             = pin1.general0;
  assign audio_serial_out_pad_drive     = pin2.audio[3];
  assign audio_word_clock_in_pad_drive  = pin2.audio[2];
  assign audio_bit_clock_in_pad_drive   = pin2.audio[1];
  assign audio_serial_in_pad_drive      = pin2.audio[0];
  assign pixel_clock_pad_drive          = pin2.pixel_clock;
  assign video_bus_pad_drive            = pin2.video_bus;
  assign vertical_sync_pad_drive        = pin2.vertical;
  assign horizontal_sync_pad_drive      = pin2.horizontal;
  assign codec_link_input_pads_drive    = pin3.link_in;
  assign codec_link_output_pads_drive   = pin3.link_out;
  assign pll_clock_pad_drive            = pin3.pll_clock;
  assign audio_word_clock_out_pad_drive = pin3.word_clock_out;
  assign audio_bit_clock_out_pad_drive  = pin3.bit_clock_out;

  // checks on the bank
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_sync_n);

  chk_filter_skip_write: assert property (
    wr_en[S_AFE3] |=> filter_skip_chan3 == $past(s.wbyte[7]))
    else $error("filter skip did not take written value");

  chk_boost_reset_on: assert property (
    $rose(rst_sync_n) |-> resistance_boost_chan1 &&
      !resistance_boost_chan2 && !resistance_boost_chan3)
    else $error("boost bits wrong after reset");

  chk_clamp_hold: assert property (
    !wr_en[S_AFE3] |=> $stable(clamp_power_chan3) &&
      $stable(clamp_power_chan2))
    else $error("clamp power changed without a write");

  chk_ref_source_write: assert property (
    wr_en[S_AFE4] |=> ref_current_source == $past(s.wbyte[3]))
    else $error("reference source did not follow write");

  chk_integer_range: assert property (
    video_synth_integer >= `AFPP_INT_MIN && video_synth_integer <=
      `AFPP_INT_MAX && second_synth_integer >= `AFPP_INT_MIN &&
      second_synth_integer <= `AFPP_INT_MAX)
    else $error("integer coefficient out of range");

  chk_postdiv_range: assert property (
    video_synth_postdiv >= `AFPP_DIV_MIN &&
      second_synth_postdiv >= `AFPP_DIV_MIN)
    else $error("post divide out of range");

  chk_fraction_low_write: assert property (
    wr_en[S_VFR0] |=> video_synth_fraction[7:0] == $past(s.wbyte))
    else $error("fraction low byte not written");

  chk_fraction_top_zero: assert property (
    s.rvalid && s.rresp == `AFPP_RESP_OKAY && $past(rd_slot) == S_VFR3
      && $past(arvalid && s.arready) |-> s.rdata[31:1] == 31'h00000000)
    else $error("fraction top reserved bits not zero");

  chk_pads_reset_off: assert property (
    $rose(rst_sync_n) |-> !field_pad_drive && !video_bus_pad_drive &&
      !pll_clock_pad_drive && !codec_link_input_pads_drive)
    else $error("pad enable set after reset");

  chk_multiplier_follow: assert property (
    (rst_sync_n && !wr_en[S_VINT]) [*2] |-> video_synth_multiplier ==
      {video_synth_integer, video_synth_fraction} || $changed(cfg_q[S_VFR0])
      || $changed(cfg_q[S_VFR1]) || $changed(cfg_q[S_VFR2])
      || $changed(cfg_q[S_VFR3]))
    else $error("multiplier lags its coefficients");

  chk_write_answer: assert property (
    do_wr |=> bvalid && !awready && !wready)
    else $error("write not answered next cycle");
endmodule

/* File: tb_top.sv */
// self-checking bench: axi4-lite master on the config bank
// assumes afpp_pkg and afpp_defs.svh are compiled ahead of it
`timescale 1ns/1ps
`include "afpp_defs.svh"
module tb_top
  import afpp_pkg::*;
;
  logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, af4;
  logic [1:0]  bresp, rresp;
  logic [7:0]  afe, pin1, pin2;
  logic [4:0]  pin3;
  logic [5:0]  vi, vd, ai, ad;
  logic [24:0] vf, sf;
  logic [30:0] vm, sm;
  int          miscompares, compares;

  afpp_regs_top afpp_regs_top_i (
    .mclk(mclk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .filter_skip_chan3(afe[7]), .filter_skip_chan2(afe[6]),
    .filter_skip_chan1(afe[5]), .resistance_boost_chan3(afe[4]),
    .resistance_boost_chan2(afe[3]), .resistance_boost_chan1(afe[2]),
    .clamp_power_chan3(afe[1]), .clamp_power_chan2(afe[0]),
    .ref_current_source(af4[3]), .ref_trim(af4[2:0]),
    .video_synth_integer(vi), .video_synth_postdiv(vd),
    .second_synth_integer(ai), .second_synth_postdiv(ad),
    .video_synth_fraction(vf), .second_synth_fraction(sf),
    .video_synth_multiplier(vm), .second_synth_multiplier(sm),
    .field_pad_drive(pin1[7]), .data_valid_pad_drive(pin1[6]),
    .infrared_send_pad_drive(pin1[5]), .infrared_receive_pad_drive(pin1[4]),
    .interrupt_pad_drive(pin1[3]), .select_or_port_clock_pad_drive(pin1[2]),
    .general_pad1_drive(pin1[1]), .general_pad0_drive(pin1[0]),
    .audio_serial_out_pad_drive(pin2[7]),
    .audio_word_clock_in_pad_drive(pin2[6]),
    .audio_bit_clock_in_pad_drive(pin2[5]),
    .audio_serial_in_pad_drive(pin2[4]), .pixel_clock_pad_drive(pin2[3]),
    .video_bus_pad_drive(pin2[2]), .vertical_sync_pad_drive(pin2[1]),
    .horizontal_sync_pad_drive(pin2[0]),
    .codec_link_input_pads_drive(pin3[4]),
    .codec_link_output_pads_drive(pin3[3]), .pll_clock_pad_drive(pin3[2]),
    .audio_word_clock_out_pad_drive(pin3[1]),
    .audio_bit_clock_out_pad_drive(pin3[0]));

  // 50 mhz clock
  always #10 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // ready sampled at negedge, so no race with the edge that takes it
  task automatic wr(input logic [9:0] i, input logic [7:0] d,
                    input logic [1:0] r);
    logic a, w, b;
    logic [1:0] s;
    @(posedge mclk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge mclk);
      a = awready;
      w = wready;
      b = bvalid;
      s = bresp;
      @(posedge mclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!b);
    bready <= 1'b0;
    chk(32'(s), 32'(r));
  endtask

  task automatic rd(input logic [9:0] i, input logic [7:0] e,
                    input logic [1:0] r);
    logic a, v;
    logic [31:0] d;
    logic [1:0] s;
    @(posedge mclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge mclk);
      a = arready;
      v = rvalid;
      d = rdata;
      s = rresp;
      @(posedge mclk);
      if (a) arvalid <= 1'b0;
    end while (!v);
    rready <= 1'b0;
    chk(d, {24'h0, e});
    chk(32'(s), 32'(r));
  endtask

  // write then read back what the register should now hold
  task automatic wrc(input logic [9:0] i, input logic [7:0] d,
                     input logic [7:0] e);
    wr(i, d, 2'h0);
    rd(i, e, 2'h0);
  endtask

  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // reset values in index order, 0x106 to 0x116
  localparam logic [7:0] RV [17] = '{8'h04, 8'h07, 8'h0F, 8'h04, 8'h0A,
    8'h10, 8'hFE, 8'hE2, 8'h2B, 8'h00, 8'h09, 8'hD7, 8'h98, 8'h00, 8'h00,
    8'h00, 8'h00};

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    wstrb = 4'h1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, miscompares, compares} = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(32'({afe, af4}), 32'h047);
    chk(32'({pin1, pin2, pin3}), 32'h0);
    chk(32'(sf), 32'h0098D709);
    chk(32'(vm), 32'({6'h0F, 25'h02BE2FE}));
    chk(32'(sm), 32'({6'h0A, 25'h098D709}));
    for (int k = 0; k < 17; k++)
      rd(10'(`AFPP_IDX_AFE3 + k), RV[k], 2'h0);
    $display("reset values test done");
    wrc(`AFPP_IDX_AFE3, 8'hFB, 8'hFB);
    wrc(`AFPP_IDX_AFE4, 8'h0A, 8'h0A);
    wrc(`AFPP_IDX_VINT, 8'h07, 8'h0F);
    wrc(`AFPP_IDX_VINT, 8'h3C, 8'h0F);
    wrc(`AFPP_IDX_VINT, 8'hC8, 8'h08);
    wrc(`AFPP_IDX_VDIV, 8'h01, 8'h04);
    wrc(`AFPP_IDX_VDIV, 8'h7F, 8'h3F);
    wrc(`AFPP_IDX_AINT, 8'h3B, 8'h3B);
    wrc(`AFPP_IDX_ADIV, 8'h02, 8'h02);
    chk(32'({afe, vi, vd, ai, ad}), 32'hFB23FEC2);
    $display("coefficient test done");
    wr(`AFPP_IDX_VFR0, 8'h12, 2'h0);
    wr(`AFPP_IDX_VFR1, 8'h34, 2'h0);
    wr(`AFPP_IDX_VFR2, 8'h56, 2'h0);
    wrc(`AFPP_IDX_VFR3, 8'hFF, 8'h01);
    wrc(`AFPP_IDX_AFR3, 8'hFE, 8'h00);
    chk(32'(vf), 32'h01563412);
    chk(32'(vm), 32'({6'h08, 25'h1563412}));
    chk(32'(sm), 32'({6'h3B, 25'h098D709}));
    $display("fraction test done");
    wrc(`AFPP_IDX_PIN1, 8'hA5, 8'hA5);
    wrc(`AFPP_IDX_PIN2, 8'h5A, 8'h5A);
    wrc(`AFPP_IDX_PIN3, 8'hFF, 8'h1F);
    wstrb <= 4'h0; // low lane off: answered but nothing stored
    wrc(`AFPP_IDX_PIN1, 8'h00, 8'hA5);
    wstrb <= 4'h1;
    chk(32'({pin1, pin2, pin3}), 32'h14AB5F);
    // unmapped place answers an error and stores nothing
    wr(10'h100, 8'hFF, 2'h2);
    rd(10'h100, 8'h00, 2'h2);
    $display("pad and unmapped test done");
    end_of_test();
  end

  // run needs under 200 cycles; 5000 gives ample margin
  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
endmodule
